// ### psd_defines.svh
/*
 program space page decoder constants: widths, page numbers, data-space address, vector addresses.
 assumes inclusion by its bare name from the package and the decoder.
*/
`ifndef PSD_DEFINES_SVH
`define PSD_DEFINES_SVH
`define PSD_PC_W          12
`define PSD_PHYS_W        13
`define PSD_PAGE_BIT      11
`define PSD_PAGE_SEL_ADDR 8'hCA
`define PSD_STATIC_PAGE   2'h1
`define PSD_PAGE_SEL_RST  2'h1
`define PSD_RESET_VEC_LO  12'hFFE
`define PSD_NMI_VEC_LO    12'hFFC
`define PSD_IRQ_VEC_LO    12'hFF0
`define PSD_IRQ_VEC_HI    12'hFF7
`define PSD_RESET_VEC_HI  12'hFFF
`define PSD_NMI_VEC_HI    12'hFFD
`define PSD_SEL_MSB       1
`define PSD_SEL_LSB       0
`define PSD_PAGE_CNT      4
`define PSD_VEC_SLOTS     3
`endif

// ### psd_pkg.sv
/*
 program space page decoder types.
 assumes psd_defines.svh is on the include path.
*/
`include "psd_defines.svh"
package psd_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
        logic       wr_en;
        logic       bit_op;
    } psd_data_wr_t;

    typedef enum logic [1:0] {
        PSD_VEC_NONE  = 2'h0,
        PSD_VEC_RESET = 2'h1,
        PSD_VEC_NMI   = 2'h2,
        PSD_VEC_IRQ   = 2'h3
    } psd_vec_t;
endpackage

// ### psd_decoder.sv
/*
 program space page decoder: maps the 12-bit program counter onto four 2-Kbyte pages.
 assumes the core drives pc and data writes synchronous to ref_clk.
*/
// Function
// - 12-bit program counter addresses a 4-Kbyte logical program window.
// - four 2-Kbyte pages; select register picks page shown at 000h-7FFh.
// - pc bit 11 set always addresses static page at 0800h-0FFFh.
// - static page also reachable low when selected; same physical locations.
// - reset, nmi and interrupt vectors sit at fixed static page addresses.
// - two-bit select: 00,01,10,11 give pages 0,1,2,3 while pc11 clear.
// - select register at data address CAh, write-only, ignores bit operations.
// - select register untouched by interrupts, calls and returns.
`timescale 1ns/10ps
`include "psd_defines.svh"
module psd_decoder
    import psd_pkg::*;
(
    input  wire logic                     ref_clk,
    input  wire logic                     rst_b,
    input  wire logic [`PSD_PC_W-1:0]     pc,
    input  wire psd_data_wr_t             data_wr,
    output logic      [`PSD_PHYS_W-1:0]   phys_addr,
    output logic                          static_hit,
    output psd_vec_t                      vec_kind
);
    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    // a byte write to the select address is the only way in; bit operations are refused
    function automatic logic psd_sel_write_hit(input psd_data_wr_t w);
        logic hit;
        hit = 1'h0;
        if (w.wr_en && !w.bit_op)
        begin
            if (w.addr == `PSD_PAGE_SEL_ADDR)
            begin
                hit = 1'h1;
            end
        end
        return hit;
    endfunction

    // only page_select_bits of the written byte are kept; the rest is ignored
    function automatic logic [1:0] psd_page_select_bits(input logic [7:0] d);
        logic [1:0] bits;
        bits = d[`PSD_SEL_MSB:`PSD_SEL_LSB];
        return bits;
    endfunction

    // page shown at a program counter value: upper half always maps to the static page
    function automatic logic [1:0] psd_page_of(
        input logic [`PSD_PC_W-1:0] a,
        input logic [1:0]           sel
    );
        logic [1:0] p;
        p = sel;
        if (a[`PSD_PAGE_BIT])
        begin
            p = `PSD_STATIC_PAGE;
        end
        return p;
    endfunction

    // inclusive range compare shared by every vector slot
    function automatic logic psd_in_range(
        input logic [`PSD_PC_W-1:0] a,
        input logic [`PSD_PC_W-1:0] lo,
        input logic [`PSD_PC_W-1:0] hi
    );
        logic hit;
        hit = (a >= lo) && (a <= hi);
        return hit;
    endfunction

    // bounds of each vector slot: 0 reset, 1 non-maskable, 2 maskable interrupts
    function automatic logic [`PSD_PC_W-1:0] psd_slot_bound(
        input int   slot,
        input logic upper
    );
        logic [`PSD_PC_W-1:0] b;
        case (slot)
            0:       b = upper ? `PSD_RESET_VEC_HI : `PSD_RESET_VEC_LO;
            1:       b = upper ? `PSD_NMI_VEC_HI : `PSD_NMI_VEC_LO;
            default: b = upper ? `PSD_IRQ_VEC_HI : `PSD_IRQ_VEC_LO;
        endcase
        return b;
    endfunction

    // the slots never overlap; the order only fixes one answer per address
    function automatic psd_vec_t psd_vec_of(input logic [`PSD_VEC_SLOTS-1:0] hit);
        psd_vec_t v;
        v = PSD_VEC_NONE;
        if (hit[0])
        begin
            v = PSD_VEC_RESET;
        end
        else if (hit[1])
        begin
            v = PSD_VEC_NMI;
        end
        else if (hit[2])
        begin
            v = PSD_VEC_IRQ;
        end
        return v;
    endfunction

    // one-hot page enables back to a page number for the physical address
    function automatic logic [1:0] psd_page_enc(input logic [`PSD_PAGE_CNT-1:0] en);
        logic [1:0] p;
        p = 2'h0;
        for (int i = 0; i < `PSD_PAGE_CNT; i++)
        begin
            if (en[i])
            begin
                p = 2'(i);
            end
        end
        return p;
    endfunction

    // ----------------------------------------
    // page select register
    // ----------------------------------------
    logic [1:0] program_page_select_q;
    logic [1:0] program_page_select_d;
    logic       sel_write;

    // reset value is a defined choice; content is unspecified to software
    // no interrupt, call or return reaches this register
    always_comb
    begin
        sel_write = psd_sel_write_hit(data_wr);
        program_page_select_d = program_page_select_q;
        if (sel_write)
        begin
            program_page_select_d = psd_page_select_bits(data_wr.data);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            program_page_select_q <= `PSD_PAGE_SEL_RST;
        end
        else
        begin
            program_page_select_q <= program_page_select_d;
        end
    end

    // ----------------------------------------
    // page enables
    // ----------------------------------------
    logic [1:0]               page_sel;
    logic [`PSD_PAGE_CNT-1:0] page_en;

    always_comb
    begin
        page_sel = psd_page_of(pc, program_page_select_q);
    end

    // one enable per physical page; exactly one is high for any program counter
    for (genvar g = 0; g < `PSD_PAGE_CNT; g++)
    begin : g_page_en
        assign page_en[g] = (page_sel == 2'(g));
    end

    // ----------------------------------------
    // vector slots
    // ----------------------------------------
    logic [`PSD_VEC_SLOTS-1:0] vec_hit;

    for (genvar s = 0; s < `PSD_VEC_SLOTS; s++)
    begin : g_vec_slot
        assign vec_hit[s] = psd_in_range(pc, psd_slot_bound(s, 1'h0), psd_slot_bound(s, 1'h1));
    end

    // ----------------------------------------
    // address output registers
    // ----------------------------------------
    logic [`PSD_PHYS_W-1:0] phys_addr_d;
    logic                   static_hit_d;

    always_comb
    begin
        phys_addr_d = {psd_page_enc(page_en), pc[`PSD_PAGE_BIT-1:0]};
        static_hit_d = page_en[`PSD_STATIC_PAGE];
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            phys_addr <= '0;
            static_hit <= 1'h0;
        end
        else
        begin
            phys_addr <= phys_addr_d;
            static_hit <= static_hit_d;
        end
    end

    // ----------------------------------------
    // vector output register
    // ----------------------------------------
    psd_vec_t vec_kind_d;

    always_comb
    begin
        vec_kind_d = psd_vec_of(vec_hit);
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            vec_kind <= PSD_VEC_NONE;
        end
        else
        begin
            vec_kind <= vec_kind_d;
        end
    end
endmodule

// ### psd_decoder_monitor.sv
/* checker on the decoder ports; assumes the bind below */
`timescale 1ns/10ps
module psd_decoder_monitor
    import psd_pkg::*;
(
    input wire logic         ref_clk,
    input wire logic         rst_b,
    input wire logic [11:0]  pc,
    input wire psd_data_wr_t data_wr,
    input wire logic [12:0]  phys_addr,
    input wire logic         static_hit,
    input wire psd_vec_t     vec_kind
);
    logic [1:0] sel_q;
    logic [1:0] sel_d;
    always_comb sel_d = (data_wr.wr_en && !data_wr.bit_op && data_wr.addr == 8'hCA) ? data_wr.data[1:0] : sel_q;
    always_ff @(posedge ref_clk or negedge rst_b)
        if (!rst_b) sel_q <= 2'h1;
        else sel_q <= sel_d;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    sequence s_wr; data_wr.wr_en && !data_wr.bit_op && data_wr.addr == 8'hCA; endsequence
    sequence s_low; !pc[11] && !data_wr.wr_en; endsequence
    chk_high_static: assert property ($past(rst_b) && $past(pc[11]) |-> phys_addr[12:11] == 2'h1) else $error("bad high");
    chk_low_page: assert property ($past(rst_b) && !$past(pc[11]) |-> phys_addr[12:11] == $past(sel_q)) else $error("bad low");
    chk_low_bits: assert property ($past(rst_b) |-> phys_addr[10:0] == $past(pc[10:0])) else $error("bad offset");
    chk_static_flag: assert property (static_hit == (phys_addr[12:11] == 2'h1)) else $error("bad flag");
    chk_sel_write: assert property (s_wr ##1 s_low |=> phys_addr[12:11] == $past(data_wr.data[1:0], 2)) else $error("lost");
    chk_reset_vec: assert property ($past(rst_b) && $past(pc[11:1]) == 11'h7FF |-> vec_kind == PSD_VEC_RESET) else $error("rv");
    chk_nmi_vec: assert property ($past(rst_b) && $past(pc[11:1]) == 11'h7FE |-> vec_kind == PSD_VEC_NMI) else $error("nv");
    chk_irq_vec: assert property ($past(rst_b) && $past(pc[11:3]) == 9'h1FE |-> vec_kind == PSD_VEC_IRQ) else $error("iv");
endmodule
bind psd_decoder psd_decoder_monitor mon (.ref_clk(ref_clk), .rst_b(rst_b), .pc(pc), .data_wr(data_wr),
    .phys_addr(phys_addr), .static_hit(static_hit), .vec_kind(vec_kind));

// ### psd_core_model.sv
/* core fetch and data-write model; assumes calls from the bench */
`timescale 1ns/10ps
module psd_core_model
    import psd_pkg::*;
(
    input wire logic    ref_clk,
    output logic [11:0] pc = 12'h800,
    output psd_data_wr_t data_wr = '0
);
    task automatic step(input logic [11:0] a, input logic [7:0] ad, input logic [7:0] d, input logic w, input logic b);
        @(posedge ref_clk);
        pc <= a;
        data_wr <= '{ad, d, w, b};
    endtask
    task automatic sel(input logic [7:0] v, input logic b);
        step(12'h800, 8'hCA, v, 1'b1, b);
    endtask
endmodule

// ### psd_decoder_tb_top.sv
/* bench for the decoder; assumes the core model drives pc and writes */
`timescale 1ns/10ps
`include "psd_defines.svh"
module psd_decoder_tb_top
    import psd_pkg::*;
();
    logic ref_clk = 1'h0, rst_b = 1'h0, static_hit;
    logic [11:0] pc;
    logic [12:0] phys_addr;
    psd_data_wr_t data_wr;
    psd_vec_t vec_kind;
    int n_fail = 0, checks = 0;
    always #5 ref_clk = ~ref_clk;
    psd_core_model core (.ref_clk(ref_clk), .pc(pc), .data_wr(data_wr));
    psd_decoder uut (.ref_clk(ref_clk), .rst_b(rst_b), .pc(pc), .data_wr(data_wr),
        .phys_addr(phys_addr), .static_hit(static_hit), .vec_kind(vec_kind));
    task automatic cmp_addr(input logic [12:0] e);
        checks++;
        if (phys_addr !== e)
        begin
            n_fail++;
            $display("unexpected %0t %h %h", $time, phys_addr, e);
        end
    endtask
    task automatic cmp_flag(input logic e);
        checks++;
        if (static_hit !== e)
        begin
            n_fail++;
            $display("unexpected %0t %h %h", $time, static_hit, e);
        end
    endtask
    task automatic cmp_vec(input psd_vec_t e);
        checks++;
        if (vec_kind !== e)
        begin
            n_fail++;
            $display("unexpected %0t %h %h", $time, vec_kind, e);
        end
    endtask
    task automatic fetch(input logic [11:0] a, input logic [12:0] e, input psd_vec_t v);
        core.step(a, 8'h00, 8'h00, 1'h0, 1'h0);
        @(posedge ref_clk) #1;
        cmp_addr(e);
        cmp_flag(e[12:11] == `PSD_STATIC_PAGE);
        cmp_vec(v);
    endtask
    task automatic scn_after_reset;
        fetch(12'h055, {`PSD_PAGE_SEL_RST, 11'h055}, PSD_VEC_NONE);
    endtask
    task automatic scn_page_sweep;
        for (int v = 0; v < 4; v++)
        begin
            core.sel(8'(v), 1'h0);
            fetch(12'h123, {2'(v), 11'h123}, PSD_VEC_NONE);
            fetch(12'h923, 13'h0923, PSD_VEC_NONE);
        end
    endtask
    task automatic scn_refused_writes;
        core.sel(8'hFE, 1'h0);
        core.sel(8'h00, 1'h1);
        core.step(12'h010, 8'hC9, 8'h03, 1'h1, 1'h0);
        fetch(12'h010, 13'h1010, PSD_VEC_NONE);
    endtask
    task automatic scn_vectors;
        fetch(12'hFFE, 13'h0FFE, PSD_VEC_RESET);
        fetch(12'hFFF, 13'h0FFF, PSD_VEC_RESET);
        fetch(12'hFFD, 13'h0FFD, PSD_VEC_NMI);
        fetch(12'hFFC, 13'h0FFC, PSD_VEC_NMI);
        fetch(12'hFF7, 13'h0FF7, PSD_VEC_IRQ);
        fetch(12'hFF0, 13'h0FF0, PSD_VEC_IRQ);
        fetch(12'hFF8, 13'h0FF8, PSD_VEC_NONE);
        fetch(12'hFEF, 13'h0FEF, PSD_VEC_NONE);
        fetch(12'h010, 13'h1010, PSD_VEC_NONE);
    endtask
    task automatic scn_mid_reset;
        @(posedge ref_clk);
        rst_b <= 1'h0;
        @(posedge ref_clk) #1;
        cmp_addr(13'h0000);
        cmp_flag(1'h0);
        cmp_vec(PSD_VEC_NONE);
        @(posedge ref_clk);
        rst_b <= 1'h1;
        fetch(12'h2AB, {`PSD_PAGE_SEL_RST, 11'h2AB}, PSD_VEC_NONE);
    endtask
    task automatic wrap_up;
        $display("fails %0d checks %0d", n_fail, checks);
        if (n_fail == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'h1;
        scn_after_reset();
        scn_page_sweep();
        scn_refused_writes();
        scn_vectors();
        scn_mid_reset();
        wrap_up();
    end
endmodule
